// [rtl/parallel_prog_port.sv]
// Parallel programming port: entry, loads, page buffer, erase, fuses.
// Assumes synchronous pins and hv_reset for the high-voltage reset.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: Load strobe rise acts by action select: address, data, command, idle.
// RULE_02: Address byte-select picks low, high or extended address byte.
// RULE_03: Low byte-select picks low or high data byte for flash.
// RULE_04: Fuse byte select: read 00 lo, 01 lock, 10 ext, 11 hi.
// RULE_05: Write strobe and output enable run the last loaded command.
// RULE_06: Commands 80 erase, 40 fuse, 20 lock, 11 EEPROM write.
// RULE_07: Command 10 enables page loading and flash page programming.
// RULE_08: Commands 08 signature, 04 fuse/lock, 02 flash, 03 EEPROM read.
// RULE_09: Ready/busy is low during internal work, high when ready.
// RULE_10: Data bus is driven only while output enable is low.
// RULE_11: Programmer holds reset, toggles load strobe six times, sets pattern.
// RULE_12: Entry pins changing within 100 ns after high voltage block entry.
// RULE_13: Programmer waits 50 us before its first command.
// RULE_14: Command and address stay loaded until explicitly reloaded.
// RULE_15: Erase clears flash, EEPROM and lock bits last; fuses kept.
// RULE_16: Preserve-EEPROM fuse programmed keeps EEPROM through erase.
// RULE_17: Write strobe after erase command starts erase, ready/busy low.
// RULE_18: Page latch copies data word into page buffer at address word.
// RULE_19: Low address bits pick the word, upper bits the page.
// RULE_20: Programmer erases chip before reprogramming flash or EEPROM.
// RULE_21: Programmer loads command once, high byte only per 256 window.
// RULE_22: Programmer may skip writing 0xFF after an erase.
// RULE_23: Write strobe with byte select 00 programs whole page, busy low; code sends only the low byte of each flash word.
// RULE_24: No-operation command ends page programming, clears write controls.
// RULE_25: Strobes are synchronised, each edge acted on once with its levels.
module parallel_prog_port
   import pp_pkg::*;
(
   input wire logic clk, // Core clock, 200 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic hv_reset, // Reset pin at its high-voltage level.
   input wire pp_pkg::pins_t pins, // Programming pins.
   output pp_pkg::bus_t bus, // Data bus output and its enable.
   output logic ready_busy_n, // High when ready, low while busy.
   output logic prog_mode, // Programming mode is active.
   output logic [7:0] fifo_data, // Programmed bytes toward the array.
   output logic fifo_valid, // A programmed byte is offered.
   input wire logic fifo_ready // The array accepts a byte.
);
   import pp_pkg::*;

   typedef struct packed {
      mode_t mode;
      op_t op;
      logic [3:0] toggles;
      logic [7:0] quiet;
      logic [3:0] pattern;
      logic [7:0] cmd;
      logic [7:0] addr_lo;
      logic [7:0] addr_hi;
      logic [7:0] addr_ext;
      logic [7:0] data_lo;
      logic [7:0] data_hi;
      logic [15:0] busy_cnt;
      logic [WORD_BITS-1:0] push_idx;
      logic [7:0] fuse_lo;
      logic [7:0] fuse_hi;
      logic [7:0] fuse_ext;
      logic [7:0] lock;
      logic [7:0] cal;
      logic lock_pending;
      logic ready;
      logic pmode;
      bus_t bus;
   } st_t;
   st_t st_ff;
   st_t nxt_st;

   logic [15:0] page_buf [PAGE_WORDS];
   logic [7:0] ee_buf [4];
   logic ls_rise;
   logic pl_rise;
   logic wr_fall;
   logic oe_lvl;
   logic f_in_valid;
   logic f_in_ready;
   logic [7:0] f_in_data;
   logic [15:0] cur_word;
   logic [15:0] rd_word;

   /////////////////////////////////////////////////////////////////////////
   // Each strobe edge becomes one single-cycle event.
   pp_edge u_ls (.clk(clk), .rst_n(rst_n), .pin(pins.load_strobe),
      .level(), .rise(ls_rise), .fall()); // RULE_25
   pp_edge u_pl (.clk(clk), .rst_n(rst_n), .pin(pins.page_latch_strobe),
      .level(), .rise(pl_rise), .fall()); // RULE_25
   pp_edge u_wr (.clk(clk), .rst_n(rst_n), .pin(pins.wr_n),
      .level(), .rise(), .fall(wr_fall)); // RULE_25
   pp_edge u_oe (.clk(clk), .rst_n(rst_n), .pin(pins.oe_n),
      .level(oe_lvl), .rise(), .fall());

   // A stalled array holds ready_busy_n low until the last page byte enters the FIFO.
   pp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk), .rst_n(rst_n),
      .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(f_in_data),
      .out_valid(fifo_valid), .out_ready(fifo_ready), .out_data(fifo_data));

   /////////////////////////////////////////////////////////////////////////
   // Decoders: byte select shared by read and write paths; fuse mux for reads.
   function automatic logic [1:0] bsel(input pins_t p);
      bsel = {p.byte_select_hi, p.byte_select_lo};
   endfunction

   function automatic logic [7:0] fuse_read(input logic [1:0] s,
         input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ex,
         input logic [7:0] lk);
      if (s == BSEL_LO) begin
         fuse_read = lo; // RULE_04
      end else if (s == BSEL_HI) begin
         fuse_read = lk;
      end else if (s == BSEL_EXT) begin
         fuse_read = ex;
      end else begin
         fuse_read = hi;
      end
   endfunction

   assign cur_word = page_buf[st_ff.push_idx];
   assign rd_word = page_buf[st_ff.addr_lo[WORD_BITS-1:0]];
   assign f_in_valid = st_ff.op inside {OP_FLASH, OP_EE} &&
      st_ff.busy_cnt == '0;
   assign f_in_data = (st_ff.op == OP_EE) ? ee_buf[st_ff.push_idx[1:0]] :
      cur_word[7:0];

   /////////////////////////////////////////////////////////////////////////
   // Main state: entry, loads, operations and read mux.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.bus.oe = 1'b0;
      case (st_ff.mode)
         MODE_IDLE: begin
            // Count load-strobe toggles, up to six, whatever the level of hv_reset.
            if (ls_rise && st_ff.toggles != TOG_W) begin
               nxt_st.toggles = st_ff.toggles + 4'h1;
            end
            nxt_st.pattern = {pins.page_latch_strobe, pins.action_sel_1,
               pins.action_sel_0, pins.byte_select_lo};
            if (hv_reset && st_ff.toggles == TOG_W &&
                  nxt_st.pattern == '0) begin
               nxt_st.mode = MODE_QUIET;
               nxt_st.quiet = '0;
            end
         end
         MODE_QUIET: begin
            // Any pattern activity in the quiet window aborts entry.
            if (!hv_reset || {pins.page_latch_strobe, pins.action_sel_1,
                  pins.action_sel_0, pins.byte_select_lo} != '0) begin
               nxt_st.mode = MODE_IDLE; // RULE_12
               nxt_st.toggles = '0;
            end else if (st_ff.quiet == QUIET_W) begin
               nxt_st.mode = MODE_PROG;
               nxt_st.pmode = 1'b1;
               nxt_st.fuse_lo = FUSE_LO_RST;
            end else begin
               nxt_st.quiet = st_ff.quiet + 8'h1;
            end
         end
         MODE_PROG: begin
            if (!hv_reset) begin
               nxt_st.mode = MODE_IDLE;
               nxt_st.pmode = 1'b0;
               nxt_st.toggles = '0;
            end
            // Loads are taken with the pin levels seen at the edge.
            if (ls_rise) begin
               case ({pins.action_sel_1, pins.action_sel_0}) // RULE_01
                  ACT_ADDR: begin
                     if (bsel(pins) == BSEL_LO) begin // RULE_02
                        nxt_st.addr_lo = pins.data;
                     end else if (bsel(pins) == BSEL_HI) begin
                        nxt_st.addr_hi = pins.data;
                     end else if (bsel(pins) == BSEL_EXT) begin
                        nxt_st.addr_ext = pins.data;
                     end
                  end
                  ACT_DATA: begin
                     if (!pins.byte_select_hi) begin // RULE_03
                        if (pins.byte_select_lo) begin
                           nxt_st.data_hi = pins.data;
                        end else begin
                           nxt_st.data_lo = pins.data;
                        end
                     end
                  end
                  ACT_CMD: begin
                     nxt_st.cmd = pins.data; // RULE_14
                     if (pins.data == CMD_NOP) begin
                        nxt_st.op = OP_NONE; // RULE_24
                        nxt_st.ready = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            // Write strobe runs the last loaded command.
            if (wr_fall && st_ff.ready) begin
               if (st_ff.cmd == CMD_ERASE) begin // RULE_05
                  nxt_st.op = OP_ERASE; // RULE_17
                  nxt_st.ready = 1'b0;
                  nxt_st.busy_cnt = ERASE_CYC_W;
                  nxt_st.lock_pending = 1'b1;
               end else if ((st_ff.cmd == CMD_WFLASH || // RULE_07
                     st_ff.cmd == CMD_WEE) && bsel(pins) == BSEL_LO) begin
                  nxt_st.op = (st_ff.cmd == CMD_WFLASH) ? OP_FLASH : OP_EE;
                  nxt_st.ready = 1'b0; // RULE_23
                  nxt_st.busy_cnt = PROG_CYC_W;
                  nxt_st.push_idx = '0;
               end else if (st_ff.cmd == CMD_WFUSE) begin // RULE_06
                  nxt_st.op = OP_FUSE;
                  nxt_st.ready = 1'b0;
                  nxt_st.busy_cnt = FUSE_CYC_W;
                  if (bsel(pins) == BSEL_LO) begin // RULE_04
                     nxt_st.fuse_lo = st_ff.data_lo;
                  end else if (bsel(pins) == BSEL_HI) begin
                     nxt_st.fuse_hi = st_ff.data_lo;
                  end else if (bsel(pins) == BSEL_EXT) begin
                     nxt_st.fuse_ext = st_ff.data_lo;
                  end
               end else if (st_ff.cmd == CMD_WLOCK) begin
                  nxt_st.op = OP_FUSE;
                  nxt_st.ready = 1'b0;
                  nxt_st.busy_cnt = FUSE_CYC_W;
                  nxt_st.lock = st_ff.lock & st_ff.data_lo;
               end
            end
            // Busy until the count and any page stream are done.
            if (!st_ff.ready) begin
               if (st_ff.busy_cnt != '0) begin
                  nxt_st.busy_cnt = st_ff.busy_cnt - 16'h1;
               end else if (st_ff.op inside {OP_FLASH, OP_EE}) begin
                  if (f_in_ready) begin
                     nxt_st.push_idx = st_ff.push_idx + 1'b1;
                     if ((st_ff.op == OP_EE && st_ff.push_idx ==
                           WORD_BITS'(3)) || (&st_ff.push_idx)) begin
                        nxt_st.ready = 1'b1; // RULE_09
                        nxt_st.op = OP_NONE;
                     end
                  end
               end else begin
                  if (st_ff.lock_pending) begin
                     nxt_st.lock = ERASED; // RULE_15
                     nxt_st.lock_pending = 1'b0;
                  end
                  nxt_st.ready = 1'b1; // RULE_09
                  nxt_st.op = OP_NONE;
               end
            end
            // Read data presented only while output enable is low.
            if (!oe_lvl) begin
               nxt_st.bus.oe = 1'b1; // RULE_10
               if (st_ff.cmd == CMD_RFUSE) begin // RULE_08
                  nxt_st.bus.dout = fuse_read(bsel(pins), st_ff.fuse_lo,
                     st_ff.fuse_hi, st_ff.fuse_ext, st_ff.lock);
               end else if (st_ff.cmd == CMD_RSIG) begin
                  if (pins.byte_select_lo) begin
                     nxt_st.bus.dout = st_ff.cal;
                  end else if (st_ff.addr_lo[1:0] == 2'h0) begin
                     nxt_st.bus.dout = SIG0;
                  end else if (st_ff.addr_lo[1:0] == 2'h1) begin
                     nxt_st.bus.dout = SIG1;
                  end else begin
                     nxt_st.bus.dout = SIG2;
                  end
               end else if (st_ff.cmd == CMD_RFLASH) begin
                  nxt_st.bus.dout = pins.byte_select_lo ?
                     rd_word[15:8] : rd_word[7:0];
               end else if (st_ff.cmd == CMD_REE) begin
                  nxt_st.bus.dout = ee_buf[st_ff.addr_lo[1:0]];
               end else begin
                  nxt_st.bus.dout = ERASED;
               end
            end
         end
         default: begin
            nxt_st.mode = MODE_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.ready <= 1'b1;
         st_ff.fuse_lo <= FUSE_LO_RST;
         st_ff.fuse_hi <= FUSE_HI_RST;
         st_ff.fuse_ext <= FUSE_EXT_RST;
         st_ff.lock <= ERASED;
         st_ff.cal <= CAL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   /////////////////////////////////////////////////////////////////////////
   // Page buffers, indexed by low address bits; upper bits name the page.
   always_ff @(posedge clk) begin
      if (st_ff.mode == MODE_PROG && pl_rise) begin
         if (st_ff.cmd == CMD_WFLASH) begin
            page_buf[st_ff.addr_lo[WORD_BITS-1:0]] <=
               {st_ff.data_hi, st_ff.data_lo}; // RULE_18 RULE_19
         end else if (st_ff.cmd == CMD_WEE) begin
            ee_buf[st_ff.addr_lo[EE_PAGE_BITS-1:0]] <= st_ff.data_lo;
         end
      end else if (st_ff.mode == MODE_PROG && wr_fall && st_ff.ready &&
            st_ff.cmd == CMD_ERASE) begin
         // A programmed preserve fuse keeps EEPROM.
         if (st_ff.fuse_hi[PRESERVE_BIT]) begin // RULE_16
            for (int i = 0; i < 4; i++) begin
               ee_buf[i] <= ERASED; // RULE_15
            end
         end
         for (int i = 0; i < PAGE_WORDS; i++) begin
            page_buf[i] <= {ERASED, ERASED};
         end
      end
   end

   assign bus = st_ff.bus;
   assign ready_busy_n = st_ff.ready;
   assign prog_mode = st_ff.pmode;
endmodule
`default_nettype wire

// [rtl/pp_edge.sv]
// Synchroniser and edge detector for one programming strobe.
// Assumes one clock; the first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module pp_edge (
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic pin, // Raw strobe pin.
   output logic level, // Synchronised level.
   output logic rise, // One-cycle pulse on a rising edge.
   output logic fall // One-cycle pulse on a falling edge.
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } st_t;
   st_t st_ff;
   st_t nxt_st;

   // Two-stage synchroniser then one stage of history.
   always_comb begin
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= {3{pin}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.s2;
   assign rise = st_ff.s2 & ~st_ff.s3;
   assign fall = ~st_ff.s2 & st_ff.s3;
endmodule
`default_nettype wire

// [rtl/pp_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
`timescale 1ns/1ps
`default_nettype none
module pp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic in_valid, // Write request.
   output logic in_ready, // Space available.
   input wire logic [WIDTH-1:0] in_data, // Write data.
   output logic out_valid, // Data available.
   input wire logic out_ready, // Consumer takes a word.
   output logic [WIDTH-1:0] out_data // Head word.
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } st_t;
   st_t st_ff;
   st_t nxt_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_wr;
   logic do_rd;

   assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
   assign out_valid = st_ff.cnt != '0;
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;
   assign out_data = mem[st_ff.rp];

   // Pointer and count update.
   always_comb begin
      nxt_st = st_ff;
      if (do_wr) begin
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (do_rd) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Storage is not reset; it holds nothing until written.
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[st_ff.wp] <= in_data;
      end
   end
endmodule
`default_nettype wire

// [rtl/pp_pkg.sv]
// Package for the parallel programming port: codes, widths, timing, types.
// Assumes a 200 MHz core clock; all pin inputs are synchronous to it.
package pp_pkg;
   localparam int CLK_MHZ = 200;
   localparam int ENTRY_QUIET_NS = 100;
   localparam int ENTRY_QUIET_CYC = (ENTRY_QUIET_NS * CLK_MHZ + 999) / 1000;
   localparam int ENTRY_TOGGLES = 6;
   localparam int PAGE_WORDS = 64;
   localparam int WORD_BITS = 6;
   localparam int EE_PAGE_BITS = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;
   // Stand-in busy times of the array, in cycles.
   localparam int ERASE_CYC = 4000;
   localparam int PROG_CYC = 1000;
   localparam int FUSE_CYC = 200;
   localparam logic [15:0] ERASE_CYC_W = 16'(ERASE_CYC);
   localparam logic [15:0] PROG_CYC_W = 16'(PROG_CYC);
   localparam logic [15:0] FUSE_CYC_W = 16'(FUSE_CYC);
   localparam logic [3:0] TOG_W = 4'(ENTRY_TOGGLES);
   localparam logic [7:0] QUIET_W = 8'(ENTRY_QUIET_CYC);
   // Strobe actions selected by the two action-select pins.
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   // Byte-select codes.
   localparam logic [1:0] BSEL_LO = 2'h0;
   localparam logic [1:0] BSEL_HI = 2'h1;
   localparam logic [1:0] BSEL_EXT = 2'h2;
   localparam logic [1:0] BSEL_RSV = 2'h3;
   // Command bytes.
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WFUSE = 8'h40;
   localparam logic [7:0] CMD_WLOCK = 8'h20;
   localparam logic [7:0] CMD_WFLASH = 8'h10;
   localparam logic [7:0] CMD_WEE = 8'h11;
   localparam logic [7:0] CMD_RSIG = 8'h08;
   localparam logic [7:0] CMD_RFUSE = 8'h04;
   localparam logic [7:0] CMD_RFLASH = 8'h02;
   localparam logic [7:0] CMD_REE = 8'h03;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] FUSE_LO_RST = 8'h5e;
   localparam logic [7:0] FUSE_HI_RST = 8'hd9;
   localparam logic [7:0] FUSE_EXT_RST = 8'hf4;
   localparam int PRESERVE_BIT = 3;
   // Arbitrary neutral identity values.
   localparam logic [7:0] SIG0 = 8'h5a;
   localparam logic [7:0] SIG1 = 8'h01;
   localparam logic [7:0] SIG2 = 8'h02;
   localparam logic [7:0] CAL_RST = 8'h80;

   typedef enum {MODE_IDLE, MODE_QUIET, MODE_PROG} mode_t;
   typedef enum {OP_NONE, OP_ERASE, OP_FLASH, OP_EE, OP_FUSE} op_t;

   // Programming pins as one bundle.
   typedef struct packed {
      logic load_strobe;
      logic page_latch_strobe;
      logic wr_n;
      logic oe_n;
      logic action_sel_1;
      logic action_sel_0;
      logic byte_select_hi;
      logic byte_select_lo;
      logic [7:0] data;
   } pins_t;

   // Data bus drive bundle.
   typedef struct packed {
      logic [7:0] dout;
      logic oe;
   } bus_t;
endpackage

// [tb/parallel_prog_port_assertions.sv]
// Checker for the parallel programming port, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module parallel_prog_port_checker (
   input wire logic clk, // Core clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic hv_reset, // High-voltage reset level.
   input wire pp_pkg::pins_t pins, // Programming pins.
   input wire pp_pkg::bus_t bus, // Data bus drive.
   input wire logic ready_busy_n, // Ready high, busy low.
   input wire logic prog_mode, // Programming mode.
   input wire logic [7:0] fifo_data, // Byte toward the array.
   input wire logic fifo_valid, // Byte offered.
   input wire logic fifo_ready // Array accepts.
);
   import pp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [3:0] pat = {pins.page_latch_strobe, pins.action_sel_1,
      pins.action_sel_0, pins.byte_select_lo};
   sequence s_wr_seen;
      !$past(pins.wr_n) || !$past(pins.wr_n, 2) || !$past(pins.wr_n, 3)
         || !$past(pins.wr_n, 4);
   endsequence
   sequence s_oe_seen;
      !pins.oe_n || !$past(pins.oe_n) || !$past(pins.oe_n, 2)
         || !$past(pins.oe_n, 3) || !$past(pins.oe_n, 4);
   endsequence
   property p_rst_quiet;
      disable iff (1'b0) !rst_n |=> ready_busy_n && !bus.oe && !prog_mode
         && !fifo_valid;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("reset state");
   property p_oe_cause;
      bus.oe |-> s_oe_seen;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven");
   property p_oe_drop;
      $rose(pins.oe_n) |-> ##[1:5] !bus.oe;
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("bus kept");
   property p_busy_cause;
      $fell(ready_busy_n) |-> s_wr_seen;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy");
   property p_busy_mode;
      !ready_busy_n |-> prog_mode;
   endproperty
   a_busy_mode: assert property (p_busy_mode) else $error("busy idle");
   property p_busy_min;
      $fell(ready_busy_n) |=> !ready_busy_n [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy short");
   property p_entry;
      $rose(prog_mode) |-> $past(hv_reset, 10) && $past(pat, 1) == 4'h0;
   endproperty
   a_entry: assert property (p_entry) else $error("entry");
   property p_exit;
      $fell(hv_reset) |-> ##[1:6] !prog_mode;
   endproperty
   a_exit: assert property (p_exit) else $error("mode kept");
   property p_fifo_hold;
      fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data);
   endproperty
   a_fifo_hold: assert property (p_fifo_hold) else $error("fifo drop");
endmodule
bind parallel_prog_port parallel_prog_port_checker
   parallel_prog_port_checker_inst (.clk(clk), .rst_n(rst_n),
   .hv_reset(hv_reset), .pins(pins), .bus(bus), .ready_busy_n(ready_busy_n),
   .prog_mode(prog_mode), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
   .fifo_ready(fifo_ready));
`default_nettype wire

// [tb/pp_programmer.sv]
// Programmer model: drives the programming pins and resolves the data bus.
// Assumes the bench calls its tasks just after falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module pp_programmer (
   input wire logic clk, // Core clock.
   input wire pp_pkg::bus_t bus, // Device drive of the data bus.
   output pp_pkg::pins_t pins // Pins as the device sees them.
);
   import pp_pkg::*;
   pins_t drv;
   initial begin
      drv = '0;
      drv.wr_n = 1'b1;
      drv.oe_n = 1'b1;
   end
   // A released bus shows the inverse of the last value, never a guess.
   always_comb begin
      pins = drv;
      pins.data = bus.oe ? bus.dout : (drv.oe_n ? drv.data : ~drv.data);
   end
   task automatic hold(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Four cycles a level, so two sync stages always see each strobe edge.
   task automatic pulse(input int k);
      if (k == 0) drv.load_strobe = 1'b1;
      if (k == 1) drv.page_latch_strobe = 1'b1;
      if (k == 2) drv.wr_n = 1'b0;
      hold(4);
      drv.load_strobe = 1'b0;
      drv.page_latch_strobe = 1'b0;
      drv.wr_n = 1'b1;
      hold(4);
   endtask
   task automatic load(input logic [1:0] act, input logic [1:0] bs,
         input logic [7:0] d);
      {drv.action_sel_1, drv.action_sel_0} = act;
      {drv.byte_select_hi, drv.byte_select_lo} = bs;
      drv.data = d;
      pulse(0);
   endtask
   task automatic read(input logic [1:0] bs, output logic [7:0] q);
      {drv.byte_select_hi, drv.byte_select_lo} = bs;
      drv.oe_n = 1'b0;
      hold(6);
      q = pins.data;
      drv.oe_n = 1'b1;
      hold(6);
   endtask
endmodule
`default_nettype wire

// [tb/tb_parallel_prog_port.sv]
// Bench: entry, reads, page load and program, fuse write, chip erase.
// Assumes the programmer model changes pins on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_prog_port;
   import pp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hv_reset = 1'b0;
   logic fifo_ready = 1'b0;
   pins_t pins;
   bus_t bus;
   logic ready_busy_n, prog_mode, fifo_valid;
   logic [7:0] fifo_data, q;
   logic [7:0] got [64];
   int errors = 0;
   int compares = 0;
   int n = 0;
   always #2.5 clk = ~clk;
   parallel_prog_port parallel_prog_port_inst (.clk(clk), .rst_n(rst_n),
      .hv_reset(hv_reset), .pins(pins), .bus(bus),
      .ready_busy_n(ready_busy_n), .prog_mode(prog_mode),
      .fifo_data(fifo_data), .fifo_valid(fifo_valid),
      .fifo_ready(fifo_ready));
   pp_programmer pp_programmer_inst (.clk(clk), .bus(bus), .pins(pins));
   // Bytes taken by the array, in order of arrival.
   always @(posedge clk) begin
      if (fifo_valid === 1'b1 && fifo_ready) begin
         if (n < 64) got[n] <= fifo_data;
         n <= n + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wait_ready(input int lim);
      int i;
      for (i = 0; i < lim && ready_busy_n !== 1'b1; i++) @(negedge clk);
      if (i == lim) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      pp_programmer_inst.load(ACT_CMD, BSEL_LO, c);
   endtask
   task automatic rd(input logic [1:0] bs, input logic [7:0] e);
      pp_programmer_inst.read(bs, q);
      chk(q, e);
   endtask
   task automatic adr(input logic [1:0] bs, input logic [7:0] a);
      pp_programmer_inst.load(ACT_ADDR, bs, a);
   endtask
   // A bad entry raises a pattern pin inside the quiet window.
   task automatic enter(input logic bad);
      hv_reset = 1'b0;
      repeat (6) pp_programmer_inst.pulse(0);
      hv_reset = 1'b1;
      repeat (2) @(negedge clk);
      pp_programmer_inst.drv.page_latch_strobe = bad;
      repeat (60) @(negedge clk);
      pp_programmer_inst.drv.page_latch_strobe = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk({6'h0, ready_busy_n, prog_mode}, 8'h02);
      enter(1'b1);
      chk({7'h0, prog_mode}, 8'h00);
      enter(1'b0);
      chk({7'h0, prog_mode}, 8'h01);
      repeat (10000) @(negedge clk);
      cmd(CMD_RSIG);
      for (int a = 0; a < 3; a++) begin
         adr(BSEL_LO, 8'(a));
         rd(BSEL_LO, a == 0 ? SIG0 : (a == 1 ? SIG1 : SIG2));
      end
      adr(BSEL_LO, 8'h00);
      rd(BSEL_HI, CAL_RST);
      cmd(CMD_RFUSE);
      rd(BSEL_LO, FUSE_LO_RST);
      rd(BSEL_EXT, FUSE_EXT_RST);
      rd(BSEL_RSV, FUSE_HI_RST);
      rd(BSEL_HI, ERASED);
      cmd(CMD_WFLASH);
      adr(BSEL_HI, 8'h00);
      adr(BSEL_LO, 8'h45);
      pp_programmer_inst.load(ACT_DATA, BSEL_LO, 8'ha5);
      pp_programmer_inst.load(ACT_DATA, BSEL_HI, 8'h3c);
      pp_programmer_inst.pulse(1);
      cmd(CMD_RFLASH);
      rd(BSEL_LO, 8'ha5);
      rd(BSEL_HI, 8'h3c);
      cmd(CMD_WFLASH);
      pp_programmer_inst.pulse(2);
      chk({7'h0, ready_busy_n}, 8'h00);
      // Stall the array until the FIFO fills.
      repeat (1200) @(negedge clk);
      fifo_ready = 1'b1;
      wait_ready(3000);
      repeat (20) @(negedge clk);
      chk(8'(n), 8'h40);
      chk(got[5], 8'ha5);
      cmd(CMD_WFUSE);
      pp_programmer_inst.load(ACT_DATA, BSEL_LO, 8'h3c);
      pp_programmer_inst.pulse(2);
      wait_ready(500);
      cmd(CMD_ERASE);
      pp_programmer_inst.pulse(2);
      chk({7'h0, ready_busy_n}, 8'h00);
      wait_ready(5000);
      cmd(CMD_RFUSE);
      rd(BSEL_LO, 8'h3c);
      cmd(CMD_RFLASH);
      rd(BSEL_LO, ERASED);
      hv_reset = 1'b0;
      repeat (10) @(negedge clk);
      chk({7'h0, prog_mode}, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
